/* File: rtl/pdpe_pkg.sv */
// Constants and types for the port D low mux and port E direction slice
package pdpe_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [11:0] PDPE_OFS_PORTD_FUNC = 12'h000;
    localparam logic [11:0] PDPE_OFS_PORTE_DIR  = 12'h004;
    localparam logic [11:0] PDPE_OFS_STATUS     = 12'h008;
    localparam logic [15:0] PDPE_RST_PORTD_FUNC = 16'h0000;
    localparam logic [15:0] PDPE_RST_PORTE_DIR  = 16'h0000;
    localparam int          PDPE_PINS           = 16;

    // ********************************************************************
    // Operating mode and port E pin function codes
    // ********************************************************************
    typedef enum logic [1:0] {
        PDPE_MODE_SINGLE   = 2'b00,
        PDPE_MODE_ROM_OFF  = 2'b01,
        PDPE_MODE_ROM_ON   = 2'b10,
        PDPE_MODE_RESERVED = 2'b11
    } pdpe_mode_t;

    typedef enum logic [1:0] {
        PDPE_FN_GPIO  = 2'b00,
        PDPE_FN_TIMER = 2'b01,
        PDPE_FN_OTHER = 2'b10,
        PDPE_FN_ALT   = 2'b11
    } pdpe_fn_t;

    // Per-pin port D routing result
    typedef struct packed {
        logic [15:0] bus_sel;
        logic [15:0] gpio_sel;
    } pdpe_route_t;

endpackage : pdpe_pkg

/* File: rtl/pdpe_mux.sv */
// Port D low pin mux and port E direction control with AHB-Lite registers
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module pdpe_mux (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [1:0]           op_mode,
    input  wire logic [31:0]          porte_func,
    output pdpe_pkg::pdpe_route_t     portd_route,
    output logic      [15:0]          porte_out_en
);
    import pdpe_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    logic [1:0]  mode_s1_r;         // Raw pin sample
    logic [1:0]  mode_s2_r;         // Synchronised sample
    logic [1:0]  mode_s3_r;         // Previous synchronised sample
    logic [1:0]  mode_r;            // Qualified operating mode
    logic [1:0]  mode_nxt;
    logic [15:0] portd_func_r;
    logic [15:0] porte_dir_r;
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;

    // ********************************************************************
    // Mode input synchroniser
    // ********************************************************************
    // Two flops before any mode logic; each bit crosses on its own
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_s1_r <= PDPE_MODE_SINGLE;
            mode_s2_r <= PDPE_MODE_SINGLE;
        end else begin
            mode_s1_r <= op_mode;
            mode_s2_r <= mode_s1_r;
        end
    end

    // ********************************************************************
    // Mode qualifier
    // ********************************************************************
    // Bits of a changing code may land a cycle apart and show a code that
    // was never driven; a new code is taken only after two equal samples,
    // so no pin flashes onto or off the data bus during a mode change
    wire         mode_same = (mode_s2_r == mode_s3_r);
    assign mode_nxt = mode_same ? mode_s2_r : mode_r;

    // Sample history and held mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_s3_r <= PDPE_MODE_SINGLE;
            mode_r    <= PDPE_MODE_SINGLE;
        end else begin
            mode_s3_r <= mode_s2_r;
            mode_r    <= mode_nxt;
        end
    end

    pdpe_mode_t mode;
    assign mode = pdpe_mode_t'(mode_r);

    // ********************************************************************
    // AHB-Lite slave decode
    // ********************************************************************
    // Address phase qualifiers and data phase write strobes
    wire         addr_ok  = hsel & hready & htrans[1];
    wire         wr_req   = addr_ok & hwrite;
    wire         rd_req   = addr_ok & ~hwrite;
    wire         hit_func = (wr_addr_r == PDPE_OFS_PORTD_FUNC);
    wire         hit_dir  = (wr_addr_r == PDPE_OFS_PORTE_DIR);
    wire         func_we  = wr_pend_r & hit_func;
    wire         dir_we   = wr_pend_r & hit_dir;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            wr_pend_r <= wr_req;
            wr_addr_r <= haddr;
        end
    end

    // ********************************************************************
    // Registers, cleared only by power-on reset
    // ********************************************************************
    // hresetn is the power-on reset; other resets and low power never reach here
    // Power-on clear only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            portd_func_r <= PDPE_RST_PORTD_FUNC;
        end else if (func_we) begin
            portd_func_r <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            porte_dir_r <= PDPE_RST_PORTE_DIR;
        end else if (dir_we) begin
            porte_dir_r <= hwdata[15:0];
        end
    end

    // ********************************************************************
    // Read data
    // ********************************************************************
    logic [31:0] rd_nxt;
    assign rd_nxt = (haddr == PDPE_OFS_PORTD_FUNC) ? {16'h0000, portd_func_r} :
                    (haddr == PDPE_OFS_PORTE_DIR)  ? {16'h0000, porte_dir_r}  :
                    (haddr == PDPE_OFS_STATUS)     ? {30'h00000000, mode_r}    :
                    32'h00000000;

    // Read data held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_req) begin
            hrdata <= rd_nxt;
        end
    end

    // ********************************************************************
    // Port D routing
    // ********************************************************************
    logic [15:0] bus_nxt;
    always_comb begin
        case (mode)
            PDPE_MODE_SINGLE:  bus_nxt = 16'h0000;
            PDPE_MODE_ROM_OFF: bus_nxt = 16'hFFFF;
            PDPE_MODE_ROM_ON:  bus_nxt = portd_func_r;
            default:           bus_nxt = 16'h0000;
        endcase
    end

    // Registered routing outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            portd_route <= '{bus_sel: 16'h0000, gpio_sel: 16'hFFFF};
        end else begin
            portd_route <= '{bus_sel: bus_nxt, gpio_sel: ~bus_nxt};
        end
    end

    // ********************************************************************
    // Port E direction
    // ********************************************************************
    logic [15:0] dir_used;
    genvar gi;
    generate
        for (gi = 0; gi < PDPE_PINS; gi++) begin : g_pe
            wire logic [1:0] fn = porte_func[2*gi+1:2*gi];
            // Direction for GPIO and timer pins
            assign dir_used[gi] = ((fn == PDPE_FN_GPIO) || (fn == PDPE_FN_TIMER))
                                  ? porte_dir_r[gi] : 1'b0;
        end
    endgenerate

    // Registered output enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            porte_out_en <= 16'h0000;
        end else begin
            porte_out_en <= dir_used;
        end
    end

endmodule // pdpe_mux

/* File: bench/pdpe_monitor.sv */
// Assertions on the outputs of the port D mux and port E direction slice
`timescale 1ns/10ps
module pdpe_monitor (
    input logic                  hclk,
    input logic                  hresetn,
    input logic [31:0]           hrdata,
    input logic [1:0]            op_mode,
    input logic [31:0]           porte_func,
    input pdpe_pkg::pdpe_route_t portd_route,
    input logic [15:0]           porte_out_en
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_route_pair: assert property (portd_route.bus_sel == ~portd_route.gpio_sel)
        else $error("pin on bus and gpio");
    a_single_gpio: assert property ((op_mode == 2'b00) [*6] |-> &portd_route.gpio_sel)
        else $error("gpio lost");
    a_reserved_gpio: assert property ((op_mode == 2'b11) [*6] |-> &portd_route.gpio_sel)
        else $error("reserved mode left gpio");
    a_rom_off_bus: assert property ((op_mode == 2'b01) [*6] |-> &portd_route.bus_sel)
        else $error("bus lost");
    a_pin0_ignored: assert property ($past(porte_func[1]) |-> !porte_out_en[0])
        else $error("pin 0 driven");
    a_pin15_ignored: assert property ($past(porte_func[31]) |-> !porte_out_en[15])
        else $error("pin 15 driven");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper set");
    a_reset_dir: assert property ($rose(hresetn) |-> porte_out_en == 16'h0)
        else $error("dir not clear");
    a_reset_route: assert property ($rose(hresetn) |-> &portd_route.gpio_sel)
        else $error("route not clear");
endmodule // pdpe_monitor
bind pdpe_mux pdpe_monitor i_mon (.hclk, .hresetn, .hrdata, .op_mode, .porte_func,
    .portd_route, .porte_out_en);

/* File: bench/pdpe_mux_bench.sv */
// Self-checking bench for the port D mux and port E direction slice
`timescale 1ns/10ps
module pdpe_mux_bench;
    import pdpe_pkg::*;
    typedef struct {logic [1:0] m; logic [15:0] f, d, b, o; logic [31:0] e;} pdpe_row_t;
    logic        hclk = 0, hresetn = 0, hwrite = 0, rdy, resp;
    logic [1:0]  htrans = 0, op_mode = 0;
    logic [11:0] haddr = 0;
    logic [15:0] porte_out_en;
    logic [31:0] hwdata = 0, hrdata, porte_func = 0, q;
    pdpe_route_t portd_route;
    int          n_errors = 0, num_checks = 0, cyc = 0;
    // Mode, function, direction, expected bus select and output enable, pin functions
    pdpe_row_t   rows[6] = '{
        '{PDPE_MODE_ROM_ON, 16'hA5A5, 16'h00FF, 16'hA5A5, 16'h00FF, 32'h0},
        '{PDPE_MODE_ROM_ON, 16'h0, 16'hFFFF, 16'h0, 16'hFFFF, 32'h5555_5555},
        '{PDPE_MODE_ROM_ON, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0, 32'hAAAA_AAAA},
        '{PDPE_MODE_SINGLE, 16'hFFFF, 16'h0F0F, 16'h0, 16'h000F, 32'hFFFF_0000},
        '{PDPE_MODE_RESERVED, 16'hFFFF, 16'h3C3C, 16'h0, 16'h3C3C, 32'h0},
        '{PDPE_MODE_ROM_OFF, 16'h0, 16'hF00F, 16'hFFFF, 16'hF00F, 32'h0000_5500}};
    pdpe_mux i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(rdy), .hrdata, .hreadyout(rdy), .hresp(resp), .op_mode, .porte_func,
        .portd_route, .porte_out_en);
    initial forever #2 hclk = ~hclk;
    // Hang guard
    always @(posedge hclk) if (++cyc == 1000) begin
        n_errors++;
        stop_test();
    end
    task automatic chk(input logic [31:0] g, e);
        num_checks++;
        if (g !== e) $display("ERROR t=%0t got %h exp %h", $time, g, e);
        n_errors += int'(g !== e);
    endtask
    // One single word transfer, waits on ready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        q = hrdata;
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        foreach (rows[i]) begin
            op_mode <= rows[i].m;
            porte_func <= rows[i].e;
            xfer(1, PDPE_OFS_PORTD_FUNC, {16'h0, rows[i].f});
            xfer(1, PDPE_OFS_PORTE_DIR, {16'h0, rows[i].d});
            repeat (4) @(posedge hclk);
            chk(portd_route.bus_sel, rows[i].b);
            chk(portd_route.gpio_sel, {16'h0, ~rows[i].b});
            chk(porte_out_en, rows[i].o);
            xfer(0, PDPE_OFS_STATUS, 0);
            chk(q, {30'h0, rows[i].m});
            chk(resp, 0);
            $display("row %0d done", i);
        end
        // Unmapped offset and upper half read as zero
        xfer(1, PDPE_OFS_PORTE_DIR, 32'hFFFF_FFFF);
        xfer(0, 12'h00C, 0);
        chk(q, 0);
        xfer(0, PDPE_OFS_PORTE_DIR, 0);
        chk(q, 32'h0000_FFFF);
        $display("read tests done");
        // Power-on reset in mid-run clears both registers
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        xfer(0, PDPE_OFS_PORTD_FUNC, 0);
        chk(q, 0);
        chk(porte_out_en, 0);
        xfer(0, PDPE_OFS_PORTE_DIR, 0);
        chk(q, 0);
        $display("reset test done");
        stop_test();
    end
endmodule // pdpe_mux_bench
